// *** hw/eesl_cfg.svh ***
`ifndef EESL_CFG_SVH
`define EESL_CFG_SVH

`define EESL_CLK_FREQ_MHZ 100
`define EESL_WR_TIME_MS   5
`define EESL_NS_PER_MS    1000
`define EESL_WR_CNT_W     20
`define EESL_DEV_CODE     4'ha
`define EESL_DEV_FIELD    7:4
`define EESL_EXT_FIELD    3:1
`define EESL_RW_BIT       0
`define EESL_MSB_BIT      7
`define EESL_NEXT_BIT     6
`define EESL_PAGE_FIELD   10:4
`define EESL_OFFS_FIELD   3:0
`define EESL_HI_FIELD     10:8
`define EESL_PAGE_BYTES   16
`define EESL_MEM_BYTES    2048
`define EESL_ERASED       8'hff
`define EESL_LAST_BIT     4'h7
`define EESL_ACK_BIT      4'h8
`define EESL_PRE_BIT      4'hf
`define EESL_MASK_2K      11'h0ff
`define EESL_MASK_4K      11'h1ff
`define EESL_MASK_8K      11'h3ff
`define EESL_MASK_16K     11'h7ff
`define EESL_SYNC_W       6
`define EESL_SYNC_RST     6'h03

`endif

// *** hw/eesl_pkg.sv ***
package eesl_pkg;

	typedef enum {
		PH_IDLE,
		PH_ADDR,
		PH_WORD,
		PH_WDATA,
		PH_RDATA,
		PH_DROP
	} eesl_phase_t;

	typedef enum logic [1:0] {
		EESL_D2K,
		EESL_D4K,
		EESL_D8K,
		EESL_D16K
	} eesl_density_t;

endpackage : eesl_pkg

// *** hw/eesl_pin_sync.sv ***
`timescale 1ns/10ps
`include "eesl_cfg.svh"

module eesl_pin_sync #(
	parameter int                     WIDTH   = 1,
	parameter logic [WIDTH-1:0]       RST_VAL = '0
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_i,
	input  wire logic [WIDTH-1:0]     async_i,
	output logic      [WIDTH-1:0]     clean_o
);

	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;
	logic [WIDTH-1:0] stage3_r;
	logic [WIDTH-1:0] differ_w;

	// stage1 feeds stage2 only; the compare looks at stages 2 and 3
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			stage1_r <= RST_VAL;
			stage2_r <= RST_VAL;
			stage3_r <= RST_VAL;
		end else begin
			stage1_r <= async_i;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
		end
	end

	assign differ_w = stage2_r ^ stage3_r;

	// a bit moves only once two stages agree, filtering single glitches
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			clean_o <= RST_VAL;
		end else begin
			clean_o <= (stage2_r & ~differ_w) | (clean_o & differ_w);
		end
	end

endmodule : eesl_pin_sync

// *** hw/eesl_slave.sv ***
// Overview of operation
// - reset returns the block to standby
// - sample on scl rise, drive after fall
// - data line only pulled low, never driven high
// - sda fall/rise with scl high: start/stop
// - nothing happens before a start; start restarts
// - address accepted only with code 1010
// - address lsb: one reads, zero writes
// - extension bits match pins or address memory
// - ninth clock acks address, word, write data
// - read: eight bits, release, continue on ack
// - byte write sequence; stop launches write cycle
// - silent and released during internal write
// - up to sixteen bytes per page write
// - write increments only low four pointer bits
// - over sixteen bytes wrap within the page
// - busy: address nacked; acked once write done
// - write protect high blocks all writes
// - protect sampled on fall before first data
// - protected: first data nacked, write discarded
// - array reads as all ones initially
// - read address acked, current byte sent
`timescale 1ns/10ps
`include "eesl_cfg.svh"

module eesl_slave #(
	parameter int                   WR_CYCLES = `EESL_WR_TIME_MS *
		`EESL_NS_PER_MS * `EESL_CLK_FREQ_MHZ
) (
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_i,
	input  wire logic                   scl_i,
	input  wire logic                   sda_i,
	output logic                        sda_o,
	output logic                        sda_oe_o,
	input  wire logic [2:0]             device_select_pins_i,
	input  wire logic                   write_protect_i,
	input  wire eesl_pkg::eesl_density_t density_sel_i,
	output logic                        write_busy_o
);
	import eesl_pkg::*;

	logic [`EESL_SYNC_W-1:0]    sync_w;
	logic                       scl_c;
	logic                       sda_c;
	logic [2:0]                 pins_c;
	logic                       wp_c;
	logic                       scl_q_r;
	logic                       sda_q_r;
	logic                       scl_rise_w;
	logic                       scl_fall_w;
	logic                       start_w;
	logic                       stop_w;
	logic                       byte_end_w;
	logic                       ack_end_w;
	logic                       match_w;
	logic                       commit_w;
	logic                       rd_next_w;
	logic [10:0]                mask_w;
	logic [7:0]                 rd_byte_w;
	eesl_phase_t                phase_r;
	logic [3:0]                 bit_cnt_r;
	logic [7:0]                 shift_r;
	logic [7:0]                 tx_r;
	logic                       first_r;
	logic                       mack_r;
	logic [2:0]                 ext_r;
	logic [10:0]                ptr_r;
	logic                       wp_lat_r;
	logic [7:0]                 page_r [0:`EESL_PAGE_BYTES-1];
	logic [`EESL_PAGE_BYTES-1:0] valid_r;
	logic [`EESL_WR_CNT_W-1:0]  wr_cnt_r;
	logic [7:0]                 mem_r [0:`EESL_MEM_BYTES-1];

	function automatic logic [10:0] addr_mask(input eesl_density_t d);
		logic [10:0] m;
		m = `EESL_MASK_16K;
		unique case (d)
			EESL_D2K:  m = `EESL_MASK_2K;
			EESL_D4K:  m = `EESL_MASK_4K;
			EESL_D8K:  m = `EESL_MASK_8K;
			EESL_D16K: m = `EESL_MASK_16K;
		endcase
		return m;
	endfunction : addr_mask

	// extension bits used as memory address are excluded from the compare
	function automatic logic dev_match(input logic [7:0] b,
		input logic [2:0] pins, input eesl_density_t d);
		logic [10:0] m;
		logic [2:0]  care;
		m    = addr_mask(d);
		care = ~m[`EESL_HI_FIELD];
		return (b[`EESL_DEV_FIELD] == `EESL_DEV_CODE) &&
			(((b[`EESL_EXT_FIELD] ^ pins) & care) == 3'h0);
	endfunction : dev_match

	eesl_pin_sync #(
		.WIDTH   (`EESL_SYNC_W),
		.RST_VAL (`EESL_SYNC_RST)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.async_i   ({write_protect_i, device_select_pins_i,
			sda_i, scl_i}),
		.clean_o   (sync_w)
	);

	assign scl_c  = sync_w[0];
	assign sda_c  = sync_w[1];
	assign pins_c = sync_w[4:2];
	assign wp_c   = sync_w[5];

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			scl_q_r <= 1'h1;
			sda_q_r <= 1'h1;
		end else begin
			scl_q_r <= scl_c;
			sda_q_r <= sda_c;
		end
	end

	assign scl_rise_w = scl_c & ~scl_q_r;
	assign scl_fall_w = ~scl_c & scl_q_r;
	assign start_w    = scl_c & scl_q_r & sda_q_r & ~sda_c;
	assign stop_w     = scl_c & scl_q_r & ~sda_q_r & sda_c;
	assign byte_end_w = scl_fall_w && bit_cnt_r == `EESL_LAST_BIT;
	assign ack_end_w  = scl_fall_w && bit_cnt_r == `EESL_ACK_BIT;
	assign mask_w     = addr_mask(density_sel_i);
	assign match_w    = dev_match(shift_r, pins_c, density_sel_i);
	assign rd_byte_w  = mem_r[ptr_r];
	assign rd_next_w  = ack_end_w && phase_r == PH_RDATA &&
		(first_r || mack_r);
	assign commit_w   = stop_w && phase_r == PH_WDATA && |valid_r;

	// the start's own scl fall wraps the pre-count to zero before bit seven
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || stop_w) begin
			bit_cnt_r <= 4'h0;
		end else if (start_w) begin
			bit_cnt_r <= `EESL_PRE_BIT;
		end else if (scl_fall_w) begin
			bit_cnt_r <= ack_end_w ? 4'h0 : bit_cnt_r + 4'h1;
		end
	end

	// busy device ignores a start entirely, so polling sees a nack
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			phase_r <= PH_IDLE;
		end else if (stop_w) begin
			phase_r <= PH_IDLE;
		end else if (start_w) begin
			phase_r <= write_busy_o ? PH_IDLE : PH_ADDR;
		end else if (byte_end_w) begin
			unique case (phase_r)
				PH_ADDR: begin
					if (!match_w)
						phase_r <= PH_DROP;
					else if (shift_r[`EESL_RW_BIT])
						phase_r <= PH_RDATA;
					else
						phase_r <= PH_WORD;
				end
				PH_WORD:  phase_r <= PH_WDATA;
				PH_WDATA: phase_r <= wp_lat_r ? PH_DROP : PH_WDATA;
				PH_RDATA: phase_r <= PH_RDATA;
				PH_IDLE:  phase_r <= PH_IDLE;
				PH_DROP:  phase_r <= PH_DROP;
			endcase
		end else if (ack_end_w && phase_r == PH_RDATA && !rd_next_w) begin
			phase_r <= PH_DROP;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			shift_r <= 8'h00;
		end else if (scl_rise_w && bit_cnt_r != `EESL_ACK_BIT &&
			(phase_r == PH_ADDR || phase_r == PH_WORD ||
			phase_r == PH_WDATA)) begin
			shift_r <= {shift_r[`EESL_NEXT_BIT:0], sda_c};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			mack_r <= 1'h0;
		end else if (scl_rise_w && bit_cnt_r == `EESL_ACK_BIT &&
			phase_r == PH_RDATA) begin
			mack_r <= ~sda_c;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ext_r <= 3'h0;
		end else if (byte_end_w && phase_r == PH_ADDR) begin
			ext_r <= shift_r[`EESL_EXT_FIELD] & mask_w[`EESL_HI_FIELD];
		end
	end

	// oe only ever pulls low; drive begins on scl falls only, a start or stop releases it
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || start_w || stop_w) begin
			sda_oe_o <= 1'h0;
			first_r  <= 1'h0;
			tx_r     <= 8'h00;
		end else if (byte_end_w) begin
			unique case (phase_r)
				PH_ADDR: begin
					sda_oe_o <= match_w;
					first_r  <= match_w & shift_r[`EESL_RW_BIT];
				end
				PH_WORD:  sda_oe_o <= 1'h1;
				PH_WDATA: sda_oe_o <= ~wp_lat_r;
				PH_RDATA: sda_oe_o <= 1'h0;
				PH_IDLE:  sda_oe_o <= 1'h0;
				PH_DROP:  sda_oe_o <= 1'h0;
			endcase
		end else if (rd_next_w) begin
			tx_r     <= rd_byte_w;
			sda_oe_o <= ~rd_byte_w[`EESL_MSB_BIT];
			first_r  <= 1'h0;
		end else if (ack_end_w) begin
			sda_oe_o <= 1'h0;
			first_r  <= 1'h0;
		end else if (scl_fall_w && phase_r == PH_RDATA) begin
			tx_r     <= {tx_r[`EESL_NEXT_BIT:0], 1'h0};
			sda_oe_o <= ~tx_r[`EESL_NEXT_BIT];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		sda_o <= 1'h0;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ptr_r <= 11'h000;
		end else if (byte_end_w && phase_r == PH_WORD) begin
			ptr_r <= {ext_r, shift_r} & mask_w;
		end else if (byte_end_w && phase_r == PH_WDATA && !wp_lat_r) begin
			ptr_r[`EESL_OFFS_FIELD] <= ptr_r[`EESL_OFFS_FIELD] + 4'h1;
		end else if (rd_next_w) begin
			ptr_r <= (ptr_r + 11'h001) & mask_w;
		end
	end

	// strobed once, on the fall that ends the word-address ack
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wp_lat_r <= 1'h0;
		end else if (ack_end_w && phase_r == PH_WDATA && valid_r == '0) begin
			wp_lat_r <= wp_c;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || start_w || stop_w) begin
			valid_r <= '0;
		end else if (byte_end_w && phase_r == PH_WDATA && !wp_lat_r) begin
			page_r[ptr_r[`EESL_OFFS_FIELD]]  <= shift_r;
			valid_r[ptr_r[`EESL_OFFS_FIELD]] <= 1'h1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			write_busy_o <= 1'h0;
			wr_cnt_r     <= '0;
		end else if (commit_w) begin
			write_busy_o <= 1'h1;
			wr_cnt_r     <= `EESL_WR_CNT_W'(WR_CYCLES - 1);
		end else if (write_busy_o) begin
			write_busy_o <= wr_cnt_r != '0;
			wr_cnt_r     <= wr_cnt_r - `EESL_WR_CNT_W'(1);
		end
	end

	// reset erases the array: trades nonvolatility for a known start
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			for (int i = 0; i < `EESL_MEM_BYTES; i++)
				mem_r[i] <= `EESL_ERASED;
		end else if (commit_w) begin
			for (int i = 0; i < `EESL_PAGE_BYTES; i++)
				if (valid_r[i])
					mem_r[{ptr_r[`EESL_PAGE_FIELD], 4'(i)}] <= page_r[i];
		end
	end

	default clocking cb_sys @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence s_addr_end;
		byte_end_w && phase_r == PH_ADDR;
	endsequence

	sequence s_wdata_end;
		byte_end_w && phase_r == PH_WDATA;
	endsequence

	property p_open_drain;
		sda_oe_o |-> !sda_o;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("sda driven high");

	property p_start_cmd;
		start_w && !write_busy_o |=> phase_r == PH_ADDR &&
			bit_cnt_r == `EESL_PRE_BIT;
	endproperty
	a_start_cmd: assert property (p_start_cmd)
		else $error("start did not open a command");

	property p_stop_idle;
		stop_w |=> phase_r == PH_IDLE && !sda_oe_o;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("stop did not return to idle");

	property p_addr_ack;
		s_addr_end ##0 match_w |=> sda_oe_o [*1] ##0 phase_r != PH_DROP;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("matching address not acked");

	property p_addr_nack;
		s_addr_end ##0 !match_w |=> !sda_oe_o && phase_r == PH_DROP;
	endproperty
	a_addr_nack: assert property (p_addr_nack)
		else $error("foreign address acked");

	property p_busy_quiet;
		write_busy_o |-> !sda_oe_o && phase_r == PH_IDLE;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet)
		else $error("device active during write cycle");

	property p_commit;
		commit_w |=> write_busy_o [*2];
	endproperty
	a_commit: assert property (p_commit)
		else $error("stop did not launch write cycle");

	property p_page_inc;
		s_wdata_end ##0 !wp_lat_r |=>
			ptr_r[`EESL_OFFS_FIELD] == $past(ptr_r[`EESL_OFFS_FIELD]) + 4'h1 &&
			$stable(ptr_r[`EESL_PAGE_FIELD]);
	endproperty
	a_page_inc: assert property (p_page_inc)
		else $error("page pointer step wrong");

	property p_wp_reject;
		s_wdata_end ##0 wp_lat_r |=> !sda_oe_o && phase_r == PH_DROP;
	endproperty
	a_wp_reject: assert property (p_wp_reject)
		else $error("protected write acked");

	property p_drive_on_fall;
		$rose(sda_oe_o) |-> $past(scl_fall_w);
	endproperty
	a_drive_on_fall: assert property (p_drive_on_fall)
		else $error("sda pulled outside a scl fall");

	property p_read_ptr;
		rd_next_w |=> ptr_r == (($past(ptr_r) + 11'h001) & $past(mask_w));
	endproperty
	a_read_ptr: assert property (p_read_ptr)
		else $error("read pointer did not advance");

endmodule : eesl_slave

// *** bench/eesl_master_model.sv ***
`timescale 1ns/10ps
module eesl_master_model (
	input  wire logic clk_sys_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// scl stands high between frames, like the idle bus
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic qtr;
		repeat (4) @(negedge clk_sys_i);
	endtask : qtr
	// only ever pulls low; a one is a released line
	task automatic bit_io(input logic b, output logic r);
		sda_low_o = !b;
		qtr();
		scl_o = 1'b1;
		qtr();
		r = sda_i;
		qtr();
		scl_o = 1'b0;
		qtr();
	endtask : bit_io
	task automatic start_c;
		sda_low_o = 1'b0;
		qtr();
		scl_o = 1'b1;
		qtr();
		sda_low_o = 1'b1;
		qtr();
		scl_o = 1'b0;
		qtr();
	endtask : start_c
	task automatic stop_c;
		sda_low_o = 1'b1;
		qtr();
		scl_o = 1'b1;
		qtr();
		sda_low_o = 1'b0;
		qtr();
	endtask : stop_c
	task automatic byte_io(input logic [7:0] tx, input logic mack,
		output logic [7:0] rx, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], b);
			rx[i] = b;
		end
		bit_io(mack, ack);
	endtask : byte_io
endmodule : eesl_master_model

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	import eesl_pkg::*;
	localparam int WR_CYC = 200;
	logic          clk_sys_i;
	logic          rst_i;
	logic          sda_o;
	logic          sda_oe;
	logic          busy;
	logic          wp;
	logic          scl;
	logic          m_low;
	logic          ack;
	logic [2:0]    pins;
	logic [7:0]    rx;
	eesl_density_t dens;
	wire logic     sda_w;
	int            failures;
	int            comparisons;
	int            mem[2048];
	int            ptr;
	int            dsel;
	int            a;
	// pull-up wins unless someone pulls low
	assign sda_w = !(m_low || (sda_oe && !sda_o));
	eesl_slave #(.WR_CYCLES(WR_CYC)) DUT (
		.clk_sys_i            (clk_sys_i),
		.rst_i                (rst_i),
		.scl_i                (scl),
		.sda_i                (sda_w),
		.sda_o                (sda_o),
		.sda_oe_o             (sda_oe),
		.device_select_pins_i (pins),
		.write_protect_i      (wp),
		.density_sel_i        (dens),
		.write_busy_o         (busy)
	);
	eesl_master_model mst (
		.clk_sys_i (clk_sys_i),
		.sda_i     (sda_w),
		.scl_o     (scl),
		.sda_low_o (m_low)
	);
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = !clk_sys_i;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude;
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	function automatic int msk();
		return (256 << dsel) - 1;
	endfunction : msk
	// low dsel extension bits carry memory address, the rest the pins
	function automatic logic [7:0] adr(input int x, input bit rd);
		int lm;
		lm = (1 << dsel) - 1;
		return 8'((32'ha0 | (((pins & ~lm) | ((x >> 8) & lm)) << 1)) | rd);
	endfunction : adr
	task automatic reset_dut;
		rst_i = 1'b1;
		repeat (5) @(negedge clk_sys_i);
		rst_i = 1'b0;
		foreach (mem[i]) mem[i] = 255;
		ptr = 0;
		repeat (8) @(negedge clk_sys_i);
		chk({busy, sda_oe, sda_o}, 3'h0);
	endtask : reset_dut
	task automatic sel(input int x);
		mst.start_c();
		mst.byte_io(adr(x, 0), 1'b1, rx, ack);
		chk(ack, 1'b0);
		mst.byte_io(x[7:0], 1'b1, rx, ack);
		chk(ack, 1'b0);
		mst.stop_c();
		ptr = x & msk();
	endtask : sel
	task automatic rd(input int n);
		mst.start_c();
		mst.byte_io(adr(ptr, 1), 1'b1, rx, ack);
		chk(ack, 1'b0);
		for (int i = 0; i < n; i++) begin
			mst.byte_io(8'hff, i == n - 1, rx, ack);
			chk(rx, mem[ptr]);
			ptr = (ptr + 1) & msk();
		end
		mst.stop_c();
	endtask : rd
	task automatic wr(input int x, input int n, input logic prot);
		logic [7:0] d;
		int         k;
		mst.start_c();
		mst.byte_io(adr(x, 0), 1'b1, rx, ack);
		chk(ack, 1'b0);
		wp = prot;
		mst.byte_io(x[7:0], 1'b1, rx, ack);
		chk(ack, 1'b0);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			mst.byte_io(d, 1'b1, rx, ack);
			chk(ack, prot);
			if (!prot)
				mem[(x & ~15 & msk()) | ((x + i) & 15)] = d;
		end
		mst.stop_c();
		wp = 1'b0;
		if (prot) begin
			repeat (20) @(negedge clk_sys_i);
			chk(busy, 1'b0);
		end else begin
			mst.start_c();
			mst.byte_io(adr(x, 0), 1'b1, rx, ack);
			chk(ack, 1'b1);
			chk(busy, 1'b1);
			mst.stop_c();
			for (k = 0; k < 400 && busy !== 1'b0; k++) @(negedge clk_sys_i);
			chk(busy, 1'b0);
			mst.start_c();
			mst.byte_io(adr(x, 0), 1'b1, rx, ack);
			chk(ack, 1'b0);
			mst.stop_c();
		end
	endtask : wr
	initial begin
		#500000;
		failures++;
		conclude();
	end
	initial begin
		failures = 0;
		comparisons = 0;
		wp = 1'b0;
		dsel = 0;
		dens = EESL_D2K;
		void'($urandom(41193));
		pins = 3'($urandom);
		reset_dut();
		rd(2);
		mst.start_c();
		mst.byte_io(8'hb0 | {4'h0, pins, 1'b0}, 1'b1, rx, ack);
		chk(ack, 1'b1);
		mst.stop_c();
		mst.start_c();
		mst.byte_io(8'ha0 | {4'h0, ~pins, 1'b1}, 1'b1, rx, ack);
		chk(ack, 1'b1);
		mst.stop_c();
		for (int s = 0; s < 4; s++) begin
			dsel = s;
			dens = eesl_density_t'(s);
			a = $urandom & msk();
			wr(a, 1, 1'b0);
			sel(a);
			rd(1);
		end
		a = $urandom & msk();
		wr(a, 18, 1'b0);
		sel(a & ~15);
		rd(16);
		wr(a, 1, 1'b1);
		sel(a);
		rd(1);
		reset_dut();
		rd(1);
		conclude();
	end
endmodule : tb_top
